/* File: cets_regs.sv */
// apb register bank: correction data space, eeprom lock/busy, temperature sensor
// Function
// - bit 16 of the eeprom control register reads 1 while the eeprom is active, else 0.
// - after reset the whole eeprom is copied into the correction space with the busy flag set.
// - the busy flag also stays set for the whole of an eeprom update.
// - correction space writes are allowed only while the key field holds 0xabcd; it resets to 0.
// - with any other key, correction space writes are dropped and the contents kept.
// - changing the key from 0xabcd to another value starts a write-back into the eeprom.
// - with auto acquire set, the temperature value is refreshed once a second.
// - with auto acquire clear, the value changes only after a software trigger.
// - writing 1 to the trigger bit starts one sensor read whose result is stored.
// - the 13-bit sensor reading is stored sign-extended to 32 bits, resetting to 0.
// - a read-only firmware version word sits at offset 0x3fc.
`timescale 1ns/1ns
module cets_regs #(
	parameter int          CORR_DEPTH  = cets_pkg::CORR_DEPTH,
	parameter int          AUTO_CYCLES = cets_pkg::AUTO_CYCLES,
	parameter logic [31:0] FW_VERSION  = cets_pkg::FW_VER_DFLT,
	parameter int          EE_ADDR_W   = $clog2(CORR_DEPTH)
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [cets_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                   pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	output logic                               ee_req,
	output logic                               ee_we,
	output logic      [EE_ADDR_W-1:0]          ee_addr,
	output logic      [31:0]                   ee_wdata,
	input  wire logic [31:0]                   ee_rdata,
	input  wire logic                          ee_ack,
	output logic                               ts_req,
	input  wire logic                          ts_ack,
	input  wire logic [cets_pkg::TEMP_W-1:0]   ts_data
);

	localparam logic [EE_ADDR_W-1:0] EE_LAST = EE_ADDR_W'(CORR_DEPTH - 1);

	// ********************************
	// helper functions
	// ********************************
	function automatic logic is_corr(input logic [cets_pkg::ADDR_W-1:0] a);
		logic [cets_pkg::ADDR_W-1:0] rel;
		rel = a - cets_pkg::OFS_CORR_BASE;
		return (a >= cets_pkg::OFS_CORR_BASE) && (32'(rel) < 32'(CORR_DEPTH * 4));
	endfunction

	function automatic logic [EE_ADDR_W-1:0] corr_index(input logic [cets_pkg::ADDR_W-1:0] a);
		logic [cets_pkg::ADDR_W-1:0] rel;
		rel = a - cets_pkg::OFS_CORR_BASE;
		return rel[EE_ADDR_W+1:2];
	endfunction

	// the reading's top bit is its sign; copy it up through bit 31
	function automatic logic [31:0] sext_temp(input logic [cets_pkg::TEMP_W-1:0] v);
		return {{(32 - cets_pkg::TEMP_W){v[cets_pkg::TEMP_W-1]}}, v};
	endfunction

	function automatic logic [31:0] merge_strb(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction

	// ********************************
	// state
	// ********************************
	logic [31:0]                 corr_mem_q [CORR_DEPTH];
	logic [15:0]                 key_q;
	logic                        upd_pend_q;
	cets_pkg::cets_ee_state_t    ee_state_q;
	logic [EE_ADDR_W-1:0]        ee_idx_q;
	logic                        auto_q;
	logic                        ts_busy_q;
	logic [31:0]                 temp_q;
	logic [31:0]                 prdata_q;

	logic                        setup_rd;
	logic                        acc_wr;
	logic                        hit_ctrl;
	logic                        hit_trig;
	logic                        hit_value;
	logic                        hit_fw;
	logic                        hit_corr;
	logic                        mapped;
	logic [31:0]                 ctrl_wr_v;
	logic [15:0]                 key_d;
	logic                        relock;
	logic                        ee_busy;
	logic                        corr_wr_ok;
	logic                        auto_tick;
	logic                        ts_start;
	logic [31:0]                 rd_d;
	logic                        wr_ctrl;
	logic                        wr_trig;
	logic                        wr_trig_go;
	logic                        load_wr;
	logic                        ee_word_done;
	logic                        ee_last_word;
	logic                        ts_done;

	// ********************************
	// apb decode
	// ********************************
	assign hit_ctrl  = (paddr == cets_pkg::OFS_EE_CTRL);
	assign hit_trig  = (paddr == cets_pkg::OFS_TEMP_MEASURE_TRIGGER);
	assign hit_value = (paddr == cets_pkg::OFS_TS_VALUE);
	assign hit_fw    = (paddr == cets_pkg::OFS_FW_VER);
	assign hit_corr  = is_corr(paddr) && (paddr[1:0] == 2'b00);
	assign mapped    = hit_ctrl || hit_trig || hit_value || hit_fw || hit_corr;

	assign setup_rd  = psel && !penable && !pwrite;
	assign acc_wr    = psel && penable && pwrite && mapped;

	// ********************************
	// response
	// ********************************
	// zero wait states; unmapped addresses answer with an error and no effect
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !mapped;
	assign prdata    = prdata_q;

	// ********************************
	// write strobes
	// ********************************
	// every write acts at the access edge, as pready never holds a transfer off
	assign wr_ctrl      = acc_wr && hit_ctrl;
	assign wr_trig      = acc_wr && hit_trig && pstrb[0];
	assign wr_trig_go   = wr_trig && pwdata[cets_pkg::TRIG_BIT];
	assign load_wr      = (ee_state_q == cets_pkg::EE_LOAD) && ee_ack;
	assign ee_word_done = ee_busy && ee_ack;
	assign ee_last_word = (ee_idx_q == EE_LAST);
	assign ts_done      = ts_busy_q && ts_ack;

	// ********************************
	// eeprom lock key
	// ********************************
	// key sits in byte lanes 0 and 1; lane 2 holds the read-only busy bit
	assign ctrl_wr_v = merge_strb({16'h0000, key_q}, pwdata, pstrb);
	assign key_d     = ctrl_wr_v[cets_pkg::KEY_W-1:0];
	assign relock    = wr_ctrl && (key_q == cets_pkg::UNLOCK_KEY)
		&& (key_d != cets_pkg::UNLOCK_KEY);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			key_q <= cets_pkg::KEY_RST;
		else if (wr_ctrl)
			key_q <= key_d;
	end

	// a relock during a running load or save is remembered and served afterwards
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			upd_pend_q <= 1'b0;
		else if (relock)
			upd_pend_q <= 1'b1;
		else if (ee_state_q == cets_pkg::EE_IDLE)
			upd_pend_q <= 1'b0;
	end

	// ********************************
	// eeprom transfer engine
	// ********************************
	// reset lands in the load state so busy is up from the first cycle
	// a relock while a save runs queues exactly one more full save
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ee_state_q <= cets_pkg::EE_LOAD;
			ee_idx_q   <= '0;
		end
		else
		begin
			unique case (ee_state_q)
				cets_pkg::EE_LOAD,
				cets_pkg::EE_SAVE:
				begin
					if (ee_word_done)
					begin
						ee_idx_q <= ee_idx_q + EE_ADDR_W'(1);
						if (ee_last_word)
						begin
							ee_idx_q   <= '0;
							ee_state_q <= cets_pkg::EE_IDLE;
						end
					end
				end
				cets_pkg::EE_IDLE:
				begin
					if (upd_pend_q)
						ee_state_q <= cets_pkg::EE_SAVE;
				end
			endcase
		end
	end

	// ********************************
	// eeprom port
	// ********************************
	// write data follows the index directly, so it is valid whenever the request is
	assign ee_busy  = (ee_state_q != cets_pkg::EE_IDLE);
	assign ee_req   = ee_busy;
	assign ee_we    = (ee_state_q == cets_pkg::EE_SAVE);
	assign ee_addr  = ee_idx_q;
	assign ee_wdata = corr_mem_q[ee_idx_q];

	// ********************************
	// correction data space
	// ********************************
	// software writes are dropped during the load so the copy cannot be torn
	// a locked write gets no error; software only sees the word unchanged
	assign corr_wr_ok = acc_wr && hit_corr && (key_q == cets_pkg::UNLOCK_KEY)
		&& (ee_state_q != cets_pkg::EE_LOAD);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < CORR_DEPTH; i++)
				corr_mem_q[i] <= 32'h0000_0000;
		end
		else if (load_wr)
			corr_mem_q[ee_idx_q] <= ee_rdata;
		else if (corr_wr_ok)
			corr_mem_q[corr_index(paddr)] <=
				merge_strb(corr_mem_q[corr_index(paddr)], pwdata, pstrb);
	end

	// ********************************
	// temperature sensor control
	// ********************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			auto_q <= cets_pkg::AUTO_RST;
		else if (wr_trig)
			auto_q <= pwdata[cets_pkg::AUTO_BIT];
	end

	// ********************************
	// auto acquire timer
	// ********************************
	cets_tick_gen #(
		.CYCLES (AUTO_CYCLES)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (auto_q),
		.tick    (auto_tick)
	);

	// a trigger is a command, not stored state; a read already running absorbs it
	// manual and timed reads share one busy flag, so a tick during a manual read is lost
	assign ts_start = !ts_busy_q && (
		wr_trig_go
		|| auto_tick);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ts_busy_q <= 1'b0;
		else if (ts_start)
			ts_busy_q <= 1'b1;
		else if (ts_ack)
			ts_busy_q <= 1'b0;
	end

	assign ts_req = ts_busy_q;

	// ********************************
	// sensor result
	// ********************************
	// an acknowledge with no read outstanding is ignored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			temp_q <= cets_pkg::TEMP_RST;
		else if (ts_done)
			temp_q <= sext_temp(ts_data);
	end

	// ********************************
	// read path
	// ********************************
	always_comb
	begin
		rd_d = 32'h0000_0000;
		if (hit_ctrl)
		begin
			rd_d[cets_pkg::KEY_W-1:0]  = key_q;
			rd_d[cets_pkg::BUSY_BIT]   = ee_busy;
		end
		else if (hit_trig)
		begin
			rd_d[cets_pkg::AUTO_BIT] = auto_q;
			rd_d[cets_pkg::TRIG_BIT] = ts_busy_q;
		end
		else if (hit_value)
			rd_d = temp_q;
		else if (hit_fw)
			rd_d = FW_VERSION;
		else if (hit_corr)
			rd_d = corr_mem_q[corr_index(paddr)];
	end

	// captured in the setup phase, presented during the access phase
	// status bits are therefore one cycle old at the access edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (setup_rd)
			prdata_q <= rd_d;
	end

endmodule

/* File: cets_pkg.sv */
// constants and types shared by the calibration eeprom / temperature register bank
package cets_pkg;

	// ********************************
	// register map
	// ********************************
	localparam int          ADDR_W        = 12;
	localparam logic [11:0] OFS_CORR_BASE = 12'h000;
	localparam logic [11:0] OFS_EE_CTRL   = 12'h3a4;
	localparam logic [11:0] OFS_TEMP_MEASURE_TRIGGER   = 12'h3a8;
	localparam logic [11:0] OFS_TS_VALUE  = 12'h3ac;
	localparam logic [11:0] OFS_FW_VER    = 12'h3fc;
	localparam int          CORR_DEPTH    = 64;

	// ********************************
	// fields and reset values
	// ********************************
	localparam int           BUSY_BIT     = 16;
	localparam int           KEY_W        = 16;
	localparam logic [15:0]  UNLOCK_KEY   = 16'habcd;
	localparam logic [15:0]  KEY_RST      = 16'h0000;
	localparam int           TRIG_BIT     = 0;
	localparam int           AUTO_BIT     = 1;
	localparam logic         AUTO_RST     = 1'b0;
	localparam int           TEMP_W       = 13;
	localparam logic [31:0]  TEMP_RST     = 32'h0000_0000;
	// arbitrary neutral value, replaced per build
	localparam logic [31:0]  FW_VER_DFLT  = 32'h0001_0000;

	// ********************************
	// timing
	// ********************************
	localparam int CLK_HZ         = 20_000_000;
	localparam int AUTO_PERIOD_MS = 1000;
	localparam int AUTO_CYCLES    = (CLK_HZ / 1000) * AUTO_PERIOD_MS;

	// ********************************
	// state machines
	// ********************************
	typedef enum logic [1:0] {EE_LOAD, EE_IDLE, EE_SAVE} cets_ee_state_t;

endpackage

/* File: cets_tick_gen.sv */
// one-cycle enable pulse every configured number of clock cycles
`timescale 1ns/1ns
module cets_tick_gen #(
	parameter int CYCLES = cets_pkg::AUTO_CYCLES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic enable,
	output logic      tick
);

	localparam int CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

	logic [CNT_W-1:0] cnt_q;
	logic             tick_q;

	// ********************************
	// divider
	// ********************************
	// restart on disable so the first pulse comes a full period after enabling
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end
		else if (!enable)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end
		else if (cnt_q == LAST)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q + CNT_W'(1);
			tick_q <= 1'b0;
		end
	end

	assign tick = tick_q;

endmodule

/* File: cets_far_model.sv */
// eeprom and temperature sensor model standing behind the register bank
`timescale 1ns/1ns
module cets_far_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ee_req,
	input  wire logic        ee_we,
	input  wire logic [5:0]  ee_addr,
	input  wire logic [31:0] ee_wdata,
	output logic      [31:0] ee_rdata,
	output logic             ee_ack,
	input  wire logic        ts_req,
	output logic             ts_ack,
	output logic      [12:0] ts_data,
	input  wire logic [12:0] temp_now,
	input  wire logic [1:0]  lat
);
	logic [31:0] mem [64];
	logic [1:0]  ecnt_q;
	logic [1:0]  tcnt_q;
	initial
	begin
		for (int i = 0; i < 64; i++)
			mem[i] = {26'h5a0000, i[5:0]};
	end
	always @(posedge pclk)
		if (ee_ack && ee_req && ee_we)
			mem[ee_addr] <= ee_wdata;
	// data lines flip when not answering, so a stale sample never passes
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			{ee_ack, ts_ack, ecnt_q, tcnt_q, ee_rdata, ts_data} <= '0;
		else
		begin
			ee_ack <= ee_req && !ee_ack && ecnt_q == lat;
			ecnt_q <= (ee_req && !ee_ack) ? ecnt_q + 2'h1 : 2'h0;
			ee_rdata <= (ee_req && !ee_ack && ecnt_q == lat) ? mem[ee_addr] : ~ee_rdata;
			ts_ack <= ts_req && !ts_ack && tcnt_q == lat;
			tcnt_q <= (ts_req && !ts_ack) ? tcnt_q + 2'h1 : 2'h0;
			ts_data <= (ts_req && !ts_ack && tcnt_q == lat) ? temp_now : ~ts_data;
		end
endmodule

/* File: cets_regs_asserts.sv */
// concurrent checks on the register bank ports
`timescale 1ns/1ns
module cets_regs_asserts #(
	parameter int          EE_ADDR_W  = 6,
	parameter logic [31:0] FW_VERSION = 32'h0000_0000
) (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [3:0]           pstrb,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic                 ee_req,
	input wire logic                 ee_we,
	input wire logic [EE_ADDR_W-1:0] ee_addr,
	input wire logic [31:0]          ee_wdata,
	input wire logic [31:0]          ee_rdata,
	input wire logic                 ee_ack,
	input wire logic                 ts_req,
	input wire logic                 ts_ack,
	input wire logic [12:0]          ts_data
);
	logic [15:0] key_q;
	logic [31:0] tv_q;
	wire         acc    = psel && penable;
	wire         wr_key = acc && pwrite && paddr == 12'h3a4 && pstrb[1:0] == 2'h3;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			key_q <= 16'h0000;
		else if (wr_key)
			key_q <= pwdata[15:0];
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			tv_q <= 32'h0000_0000;
		else if (ts_req && ts_ack)
			tv_q <= {{19{ts_data[12]}}, ts_data};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence rd_s(logic [11:0] a);
		acc && !pwrite && paddr == a;
	endsequence
	sequence save_s;
		ee_req && ee_we;
	endsequence
	busy_key_read_a: assert property (rd_s(12'h3a4) |->
		prdata == {15'h0000, $past(ee_req), $past(key_q)}) else $error("status read wrong");
	load_start_a: assert property ($rose(presetn) |-> ee_req && !ee_we && ee_addr == '0)
		else $error("load not started");
	word_step_a: assert property (ee_req && ee_ack && ee_addr != '1 |=>
		ee_req && ee_addr == $past(ee_addr) + 1'b1) else $error("word step wrong");
	last_word_a: assert property (ee_req && ee_ack && ee_addr == '1 |=> !ee_req)
		else $error("busy after last word");
	word_hold_a: assert property (ee_req && !ee_ack |=>
		ee_req && $stable(ee_addr) && $stable(ee_we)) else $error("eeprom request moved");
	relock_save_a: assert property (wr_key && key_q == 16'habcd && pwdata[15:0] != 16'habcd
		&& !ee_req |-> ##[1:4] save_s) else $error("no write-back after relock");
	trig_start_a: assert property (acc && pwrite && paddr == 12'h3a8 && pstrb[0] && pwdata[0]
		&& !ts_req |=> ts_req) else $error("trigger ignored");
	ts_hold_a: assert property (ts_req && !ts_ack |=> ts_req)
		else $error("sensor request dropped");
	temp_read_a: assert property (rd_s(12'h3ac) |-> prdata == $past(tv_q))
		else $error("temperature value wrong");
	fw_read_a: assert property (rd_s(12'h3fc) |-> prdata == FW_VERSION)
		else $error("version word wrong");
	unmapped_err_a: assert property (acc && (paddr[1:0] != 2'h0 || paddr == 12'h3b0) |->
		pslverr && pready) else $error("unmapped access not refused");
endmodule

/* File: tb_top.sv */
// self-checking bench for the correction eeprom and temperature register bank
`timescale 1ns/1ns
module tb_top;
	localparam int          AUTO = 50;
	localparam logic [31:0] FW   = 32'h0002_0300; // arbitrary value
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, ee_rdata, ee_wdata, rv, wd;
	logic [3:0]  pstrb = 4'hf;
	logic [5:0]  ee_addr;
	logic [12:0] ts_data, temp_now = '0, t;
	logic [1:0]  lat = '0;
	logic        pready, pslverr, ee_req, ee_we, ee_ack, ts_req, ts_ack, re;
	int          errors = 0, cmp_count = 0, seed = 68;
	always #25 pclk = ~pclk;
	cets_regs #(.AUTO_CYCLES(AUTO), .FW_VERSION(FW)) i_cets_regs (
		.pclk     (pclk),
		.presetn  (presetn),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.pstrb    (pstrb),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.ee_req   (ee_req),
		.ee_we    (ee_we),
		.ee_addr  (ee_addr),
		.ee_wdata (ee_wdata),
		.ee_rdata (ee_rdata),
		.ee_ack   (ee_ack),
		.ts_req   (ts_req),
		.ts_ack   (ts_ack),
		.ts_data  (ts_data)
	);
	cets_far_model i_cets_far_model (
		.pclk     (pclk),
		.presetn  (presetn),
		.ee_req   (ee_req),
		.ee_we    (ee_we),
		.ee_addr  (ee_addr),
		.ee_wdata (ee_wdata),
		.ee_rdata (ee_rdata),
		.ee_ack   (ee_ack),
		.ts_req   (ts_req),
		.ts_ack   (ts_ack),
		.ts_data  (ts_data),
		.temp_now (temp_now),
		.lat      (lat)
	);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic idle_wait;
		do apb(0, 12'h3a4, 0); while (rv[16] !== 1'b0);
	endtask
	function automatic logic [31:0] sx(input logic [12:0] v);
		return {{19{v[12]}}, v};
	endfunction
	task automatic measure(input logic [12:0] v);
		t = v;
		temp_now <= v;
		lat <= 2'($random(seed));
		apb(1, 12'h3a8, 32'h0000_0001);
		do apb(0, 12'h3a8, 0); while (rv[0] !== 1'b0);
		apb(0, 12'h3ac, 0);
		chk(rv, sx(v));
	endtask
	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		idle_wait;
		chk(rv, 32'h0);
		apb(0, 12'h3a8, 0);
		chk(rv, 32'h0);
		apb(0, 12'h3ac, 0);
		chk(rv, 32'h0);
		apb(0, 12'h3fc, 0);
		chk(rv, FW);
		apb(0, 12'h014, 0);
		chk(rv, {26'h5a0000, 6'h05});
		$display("test reset values done");
		wd = $random(seed);
		apb(1, 12'h00c, wd);
		apb(0, 12'h00c, 0);
		chk(rv, {26'h5a0000, 6'h03});
		apb(1, 12'h3a4, 32'h0000_abcd);
		apb(1, 12'h00c, wd);
		apb(0, 12'h00c, 0);
		chk(rv, wd);
		apb(1, 12'h3a4, 32'hffff_1234);
		apb(0, 12'h3a4, 0);
		chk(rv & 32'hfffe_ffff, 32'h0000_1234);
		idle_wait;
		chk(i_cets_far_model.mem[3], wd);
		$display("test lock and write-back done");
		apb(1, 12'h3b0, 32'hffff_ffff);
		chk({31'h0, re}, 32'h1);
		$display("test unmapped access done");
		measure(13'h1000);
		measure(13'h0fff);
		chk(32'($signed(rv) / 256), 32'h0000_000f);
		repeat (5) measure(13'($random(seed)));
		temp_now <= 13'h0123;
		apb(1, 12'h3a8, 32'h0000_0000);
		repeat (10) @(posedge pclk);
		apb(0, 12'h3ac, 0);
		chk(rv, sx(t));
		$display("test manual trigger done");
		temp_now <= 13'h1f00;
		apb(1, 12'h3a8, 32'h0000_0002);
		repeat (AUTO + 20) @(posedge pclk);
		apb(0, 12'h3ac, 0);
		chk(rv, sx(13'h1f00));
		apb(1, 12'h3a8, 32'h0000_0000);
		$display("test auto acquire done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		idle_wait;
		chk(rv, 32'h0);
		apb(0, 12'h00c, 0);
		chk(rv, wd);
		$display("test second reset done");
		end_sim;
	end
	initial
	begin
		repeat (30000) @(posedge pclk);
		errors++;
		end_sim;
	end
endmodule
bind cets_regs cets_regs_asserts #(.EE_ADDR_W(EE_ADDR_W), .FW_VERSION(FW_VERSION))
	i_cets_regs_asserts (
		.pclk     (pclk),
		.presetn  (presetn),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.pstrb    (pstrb),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.ee_req   (ee_req),
		.ee_we    (ee_we),
		.ee_addr  (ee_addr),
		.ee_wdata (ee_wdata),
		.ee_rdata (ee_rdata),
		.ee_ack   (ee_ack),
		.ts_req   (ts_req),
		.ts_ack   (ts_ack),
		.ts_data  (ts_data)
	);
